// *** hw/irq_arbiter.sv ***
/*
 * Combinational arbiter: picks the highest pending request and gives its
 * level and vector offset.
 * Assumes synchronised request inputs and the current priority level.
 */
`timescale 1ns/10ps
`include "irq_prio_cfg.svh"

module irq_arbiter
	import irq_prio_pkg::*;
(
	input  wire irq_src_t            src,
	input  wire logic [`SW_LINES-1:0] sw_req,
	input  wire logic [4:0]          cur_level,
	output irq_grant_t               grant
);

	logic [4:0] sw_lvl;
	logic       sw_any;

	// Highest software request, levels 01 to 0f
	always_comb begin
		sw_lvl = `LVL_NONE;
		sw_any = 1'b0;
		for (int i = 0; i < `SW_LINES; i++) begin
			if (sw_req[i]) begin
				sw_lvl = 5'(i + 1);
				sw_any = 1'b1;
			end
		end
	end

	// Fixed priority walk from the top level down
	always_comb begin
		grant = '0;
		if (src.halt) begin
			grant.nonmask = 1'b1;
			grant.level   = `LVL_HALT;
		end else if (src.wr_err) begin
			grant.level  = `LVL_WRITE_ERR;
			grant.vector = `VEC_WRITE_ERR;
		end else if (src.perf_mon) begin
			grant.level     = `LVL_PERF_MON;
			grant.microcode = 1'b1;
		end else if (src.rd_err) begin
			grant.level  = `LVL_READ_ERR;
			grant.vector = `VEC_READ_ERR;
		end else if (src.irq3) begin
			grant.level  = `LVL_IRQ3;
			grant.vector = `VEC_IRQ3;
		end else if (src.irq2) begin
			grant.level  = `LVL_IRQ2_TIMER;
			grant.vector = `VEC_IRQ2;
		end else if (src.timer) begin
			grant.level  = `LVL_IRQ2_TIMER;
			grant.vector = `VEC_TIMER;
		end else if (src.irq1) begin
			grant.level  = `LVL_IRQ1_NET;
			grant.vector = `VEC_IRQ1;
		end else if (src.irq0) begin
			grant.level  = `LVL_IRQ1_NET;
			grant.vector = `VEC_IRQ0;
		end else if (src.net) begin
			grant.level  = `LVL_IRQ1_NET;
			grant.vector = `VEC_NET;
		end else if (sw_any) begin
			grant.level  = sw_lvl;
			grant.vector = `VEC_SW_BASE + {3'h0, sw_lvl, 2'h0};
		end
		// Maskable only above current level; halt always
		grant.take = grant.nonmask ||
			(grant.level != `LVL_NONE && grant.level > cur_level);
	end

endmodule

// *** hw/irq_prio_cfg.svh ***
/*
 * Constants for the interrupt priority and exception unit: priority levels,
 * vector table offsets, halt code and field widths.
 * Assumes inclusion by the design modules by bare name.
 */
`ifndef IRQ_PRIO_CFG_SVH
`define IRQ_PRIO_CFG_SVH

// Priority levels (hex)
`define LVL_HALT        5'h1f
`define LVL_WRITE_ERR   5'h1d
`define LVL_PERF_MON    5'h1b
`define LVL_READ_ERR    5'h1a
`define LVL_IRQ3        5'h17
`define LVL_IRQ2_TIMER  5'h16
`define LVL_IRQ1_NET    5'h15
`define LVL_SW_TOP      5'h0f
`define LVL_NONE        5'h00

// Vector table offsets (hex)
`define VEC_WRITE_ERR   10'h060
`define VEC_READ_ERR    10'h054
`define VEC_TIMER       10'h0c0
`define VEC_NET         10'h104
`define VEC_SW_BASE     10'h080
`define VEC_IRQ3        10'h000
`define VEC_IRQ2        10'h000
`define VEC_IRQ1        10'h000
`define VEC_IRQ0        10'h000

// Halt code for an external halt
`define HALT_CODE_EXT   6'h02

// Software request lines, levels 01 to 0f
`define SW_LINES        15

`endif

// *** hw/irq_prio_pkg.sv ***
/*
 * Types for the interrupt priority and exception unit.
 * Assumes irq_prio_cfg.svh is on the include path.
 */
package irq_prio_pkg;

	// Hardware request sources, one bit each
	typedef struct packed {
		logic halt;
		logic wr_err;
		logic perf_mon;
		logic rd_err;
		logic irq3;
		logic irq2;
		logic timer;
		logic irq1;
		logic irq0;
		logic net;
	} irq_src_t;

	// Outcome of arbitration, sent to the core
	typedef struct packed {
		logic       take;
		logic       nonmask;
		logic       microcode;
		logic [4:0] level;
		logic [9:0] vector;
	} irq_grant_t;

	// Exception categories
	typedef enum logic [2:0] {
		exc_arith  = 3'h0,
		exc_memmgt = 3'h1,
		exc_operand= 3'h2,
		exc_instr  = 3'h3,
		exc_trace  = 3'h4,
		exc_sysfail= 3'h5
	} exc_cat_t;

	// Exception types
	typedef enum logic [1:0] {
		exc_trap  = 2'h0,
		exc_fault = 2'h1,
		exc_abort = 2'h2
	} exc_kind_t;

	// Exception report from the execution pipeline
	typedef struct packed {
		logic        valid;
		exc_cat_t    cat;
		exc_kind_t   kind;
		logic        restorable;
		logic [31:0] pc_cur;
		logic [31:0] pc_next;
	} exc_req_t;

	// Entry sequence states, gray along the usual path
	typedef enum logic [1:0] {
		st_idle  = 2'b00,
		st_save  = 2'b01,
		st_raise = 2'b11,
		st_xfer  = 2'b10
	} entry_st_t;

endpackage

// *** hw/irq_prio_unit.sv ***
/*
 * Interrupt priority and exception unit. Samples request pins, arbitrates,
 * runs the entry sequence (save, raise level, transfer) and reports the
 * saved program counter for exceptions.
 * Assumes one 100 MHz clock, synchronous active-low reset, and a core that
 * accepts a started entry with entry_ack one cycle or more later.
 */
// What this block does
// - External halt is nonmaskable, top level 1f, halt code 2.
// - Write-path errors request level 1d, vector offset 60.
// - Read and memory integrity errors request level 1a, vector 54.
// - Peripheral bus error during I/O read requests level 1a, vector 54.
// - Performance monitor takes level 1b, handled by microcode, no vector.
// - Line 3 at 17; line 2 beats timer at 16; timer c0, network 104.
// - Each exception is put in one of six categories.
// - Trap taken after instruction; saved PC is the next instruction.
// - Abort may be unpredictable; microcode converts it to fault if it can.
// - Halt saves PC, status word, mapping bit, halt code; level 1f; firmware.
// - Maskable request saves PC and status word, raises level, vectors; the monitor goes to microcode instead.
// - Raising the priority level never blocks the halt request.
`timescale 1ns/10ps
`include "irq_prio_cfg.svh"

module irq_prio_unit
	import irq_prio_pkg::*;
(
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	input  wire logic                 halt_pin,
	input  wire logic [3:0]           irq_pin,
	input  wire logic                 io_bus_err_pin,
	input  wire logic                 wr_err_req,
	input  wire logic                 rd_err_req,
	input  wire logic                 perf_mon_req,
	input  wire logic                 timer_req,
	input  wire logic                 net_req,
	input  wire logic [`SW_LINES-1:0] sw_req,
	input  wire logic [4:0]           cur_level,
	input  wire logic [31:0]          cur_pc,
	input  wire logic [31:0]          cur_psw,
	input  wire logic                 mapping_enable_bit,
	input  wire logic                 instr_done,
	input  wire exc_req_t             exc_in,
	input  wire logic                 entry_ack,
	output logic                      entry_start,
	output logic                      entry_to_firmware,
	output logic                      entry_microcode,
	output logic [4:0]                new_level,
	output logic [9:0]                vector_offset,
	output logic [31:0]               saved_pc,
	output logic [31:0]               saved_psw,
	output logic                      saved_map_en,
	output logic [5:0]                saved_halt_code,
	output logic                      exc_valid,
	output exc_cat_t                  exc_cat,
	output exc_kind_t                 exc_kind,
	output logic                      exc_restore
);

	logic [5:0]  pin_s1_r;
	logic [5:0]  pin_s2_r;
	irq_src_t    src;
	irq_grant_t  grant;
	entry_st_t   st_r;
	entry_st_t   st_nxt;
	irq_grant_t  held_r;
	exc_req_t    exc_pend_r;
	logic        entry_save;
	logic        exc_deliver;

	// Two-stage sync of pins: halt, irq[3:0], peripheral bus error
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pin_s1_r <= 6'h00;
			pin_s2_r <= 6'h00;
		end else begin
			pin_s1_r <= {io_bus_err_pin, irq_pin, halt_pin};
			pin_s2_r <= pin_s1_r;
		end
	end

	// Gather sources; unused levels have no input at all
	// Pin sources come from the second sync stage only
	always_comb begin
		src          = '0;
		src.halt     = pin_s2_r[0];
		src.wr_err   = wr_err_req;
		src.perf_mon = perf_mon_req;
		src.rd_err   = rd_err_req | pin_s2_r[5];
		src.irq3     = pin_s2_r[4];
		src.irq2     = pin_s2_r[3];
		src.irq1     = pin_s2_r[2];
		src.irq0     = pin_s2_r[1];
		src.timer    = timer_req;
		src.net      = net_req;
	end

	irq_arbiter irq_arbiter_i (
		.src       (src),
		.sw_req    (sw_req),
		.cur_level (cur_level),
		.grant     (grant)
	);

	// Entry sequence: idle, save, raise level, transfer
	// A halt leaves idle at once; a maskable request waits for a boundary
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			st_idle: begin
				if (grant.take && (grant.nonmask || instr_done))
					st_nxt = st_save;
			end
			st_save:  st_nxt = st_raise;
			st_raise: st_nxt = st_xfer;
			st_xfer: begin
				if (entry_ack)
					st_nxt = st_idle;
			end
			default:  st_nxt = st_idle;
		endcase
	end

	// State register
	always_ff @(posedge clock) begin
		if (!rst_n)
			st_r <= st_idle;
		else
			st_r <= st_nxt;
	end

	// Entry starts on this edge; it owns saved_pc for the cycle
	assign entry_save = st_r == st_idle && st_nxt == st_save;

	// Latch grant and save state at the start of entry
	// The held grant keeps level and vector steady while the request drops
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			held_r          <= '0;
			saved_psw       <= 32'h0;
			saved_map_en    <= 1'b0;
			saved_halt_code <= 6'h00;
		end else if (entry_save) begin
			held_r    <= grant;
			saved_psw <= cur_psw;
			if (grant.nonmask) begin
				saved_map_en    <= mapping_enable_bit;
				saved_halt_code <= `HALT_CODE_EXT;
			end
		end
	end

	// Core-facing entry outputs, each from a flip-flop
	// The start pulse covers the first transfer cycle only
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			entry_start       <= 1'b0;
			entry_to_firmware <= 1'b0;
			entry_microcode   <= 1'b0;
			new_level         <= 5'h00;
			vector_offset     <= 10'h000;
		end else begin
			entry_start <= (st_nxt == st_xfer) && (st_r == st_raise);
			if (st_r == st_save) begin
				new_level         <= held_r.level;
				vector_offset     <= held_r.vector;
				entry_to_firmware <= held_r.nonmask;
				entry_microcode   <= held_r.microcode;
			end
		end
	end

	// Pending report goes out now: faults at once, traps at the boundary;
	// an entry save in the same cycle owns saved_pc, so the report waits
	assign exc_deliver = exc_pend_r.valid && !entry_save &&
		(exc_pend_r.kind != exc_trap || instr_done);

	// Hold an exception report until it is delivered; a new report wins
	always_ff @(posedge clock) begin
		if (!rst_n)
			exc_pend_r <= '0;
		else if (exc_in.valid)
			exc_pend_r <= exc_in;
		else if (exc_deliver)
			exc_pend_r.valid <= 1'b0;
	end

	// Saved PC: interrupts take cur_pc, traps the next PC, faults the current one
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			saved_pc    <= 32'h0;
			exc_valid   <= 1'b0;
			exc_cat     <= exc_arith;
			exc_kind    <= exc_trap;
			exc_restore <= 1'b0;
		end else begin
			exc_valid <= exc_deliver;
			if (entry_save) begin
				saved_pc <= cur_pc;
			end else if (exc_deliver) begin
				if (exc_pend_r.kind == exc_trap)
					saved_pc <= exc_pend_r.pc_next;
				else
					saved_pc <= exc_pend_r.pc_cur;
			end
			if (exc_pend_r.valid) begin
				exc_cat  <= exc_pend_r.cat;
				// Abort that microcode can restore is reported as a fault
				if (exc_pend_r.kind == exc_abort && exc_pend_r.restorable)
					exc_kind <= exc_fault;
				else
					exc_kind <= exc_pend_r.kind;
				exc_restore <= exc_pend_r.kind == exc_abort && exc_pend_r.restorable;
			end
		end
	end

endmodule

// *** verif/core_model.sv ***
/*
 * Processor core stand-in: instruction boundaries and entry acceptance.
 * Assumes the unit's clock and synchronous active-low reset.
 */
`timescale 1ns/10ps
module core_model (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic slow,
	input  wire logic entry_start,
	output logic      entry_ack,
	output logic      instr_done
);
	logic [1:0] cnt_r;
	logic [2:0] wait_r;
	// An instruction ends every fourth cycle
	always_ff @(posedge clock) begin
		if (!rst_n)
			cnt_r <= 2'h0;
		else
			cnt_r <= cnt_r + 2'h1;
	end
	assign instr_done = rst_n && cnt_r == 2'h3;
	// Accept an entry after one cycle, or five when slow
	always_ff @(posedge clock) begin
		if (!rst_n || entry_ack)
			wait_r <= 3'h0;
		else if (entry_start)
			wait_r <= slow ? 3'h5 : 3'h1;
		else if (wait_r > 3'h1)
			wait_r <= wait_r - 3'h1;
	end
	assign entry_ack = wait_r == 3'h1;
endmodule

// *** verif/irq_prio_sva.sv ***
/*
 * Port checker for the interrupt priority and exception unit.
 * Assumes a bind onto irq_prio_unit and a steady cur_level around each entry.
 */
`timescale 1ns/10ps
module irq_prio_sva
	import irq_prio_pkg::*;
(
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        halt_pin,
	input wire logic        instr_done,
	input wire logic [4:0]  cur_level,
	input wire exc_req_t    exc_in,
	input wire logic        entry_start,
	input wire logic        entry_to_firmware,
	input wire logic        entry_microcode,
	input wire logic [4:0]  new_level,
	input wire logic [9:0]  vector_offset,
	input wire logic [31:0] saved_pc,
	input wire logic [5:0]  saved_halt_code,
	input wire logic        exc_valid,
	input wire exc_kind_t   exc_kind
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Entry kinds tied to their level and vector offset; then bounds, pulse, saved PC and trap timing
	property p_halt;
		entry_start && entry_to_firmware |-> new_level == 5'h1f && saved_halt_code == 6'h02;
	endproperty
	a_halt: assert property (p_halt) else $error("halt entry level or code wrong");
	property p_halt_bound;
		$rose(halt_pin) |-> ##[1:40] (entry_start && entry_to_firmware);
	endproperty
	a_halt_bound: assert property (p_halt_bound) else $error("halt not taken");
	property p_wr;
		entry_start && new_level == 5'h1d |-> vector_offset == 10'h060;
	endproperty
	a_wr: assert property (p_wr) else $error("write error vector wrong");
	property p_rd;
		entry_start && new_level == 5'h1a |-> vector_offset == 10'h054;
	endproperty
	a_rd: assert property (p_rd) else $error("read error vector wrong");
	property p_perf;
		entry_start && entry_microcode |-> new_level == 5'h1b;
	endproperty
	a_perf: assert property (p_perf) else $error("monitor level wrong");
	property p_timer;
		entry_start && vector_offset == 10'h0c0 |-> new_level == 5'h16;
	endproperty
	a_timer: assert property (p_timer) else $error("timer level wrong");
	property p_grant;
		entry_start && !entry_to_firmware && !entry_microcode |-> new_level > $past(cur_level, 3);
	endproperty
	a_grant: assert property (p_grant) else $error("granted at or below level");
	property p_fault;
		exc_valid && exc_kind == exc_fault |-> saved_pc == $past(exc_in.pc_cur, 2);
	endproperty
	a_fault: assert property (p_fault) else $error("fault saved pc wrong");
	property p_pulse;
		entry_start |=> !entry_start;
	endproperty
	a_pulse: assert property (p_pulse) else $error("entry start not a pulse");
	property p_levels;
		entry_start |-> new_level inside {5'h1f, 5'h1d, 5'h1b, 5'h1a,
			[5'h15:5'h17], [5'h01:5'h0f]};
	endproperty
	a_levels: assert property (p_levels) else $error("entry at an unused level");
	property p_trap;
		exc_valid && exc_kind == exc_trap |-> $past(instr_done);
	endproperty
	a_trap: assert property (p_trap) else $error("trap taken inside an instruction");
	// Main scenarios reached
	c_halt: cover property (entry_start && entry_to_firmware);
	c_perf: cover property (entry_start && entry_microcode);
	c_trap: cover property (exc_valid && exc_kind == exc_trap);
endmodule
bind irq_prio_unit irq_prio_sva irq_prio_sva_i (.clock, .rst_n, .halt_pin, .cur_level, .exc_in,
	.entry_start, .entry_to_firmware, .entry_microcode, .new_level, .vector_offset, .saved_pc,
	.saved_halt_code, .exc_valid, .exc_kind, .instr_done);

// *** verif/irq_prio_unit_bench.sv ***
/*
 * Self-checking bench for the interrupt priority and exception unit.
 * Assumes core_model as the core and the port checker bound in.
 */
`timescale 1ns/10ps
module irq_prio_unit_bench;
	import irq_prio_pkg::*;
	logic        clock = 1'b0, rst_n = 1'b0, slow = 1'b0, mapping_enable_bit = 1'b1;
	logic        halt_pin = 1'b0, io_bus_err_pin = 1'b0, wr_err_req = 1'b0, rd_err_req = 1'b0;
	logic        perf_mon_req = 1'b0, timer_req = 1'b0, net_req = 1'b0;
	logic [3:0]  irq_pin = 4'h0;
	logic [14:0] sw_req = 15'h0000;
	logic [4:0]  cur_level = 5'h00, new_level;
	logic [31:0] cur_pc = 32'h0000_1000, cur_psw = 32'h0000_0004, saved_pc, saved_psw;
	exc_req_t    exc_in = '0;
	logic        entry_ack, instr_done, entry_start, entry_to_firmware, entry_microcode;
	logic        saved_map_en, exc_valid, exc_restore, got;
	logic [9:0]  vector_offset;
	logic [5:0]  saved_halt_code;
	exc_cat_t    exc_cat;
	exc_kind_t   exc_kind;
	int          errors = 0, checked = 0;
	irq_prio_unit irq_prio_unit_i (.clock, .rst_n, .halt_pin, .irq_pin, .io_bus_err_pin,
		.wr_err_req, .rd_err_req, .perf_mon_req, .timer_req, .net_req, .sw_req, .cur_level,
		.cur_pc, .cur_psw, .mapping_enable_bit, .instr_done, .exc_in, .entry_ack, .entry_start,
		.entry_to_firmware, .entry_microcode, .new_level, .vector_offset, .saved_pc, .saved_psw,
		.saved_map_en, .saved_halt_code, .exc_valid, .exc_cat, .exc_kind, .exc_restore);
	core_model core_model_i (.clock, .rst_n, .slow, .entry_start, .entry_ack, .instr_done);
	always #5 clock = ~clock;
	// Compare and count
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Wait a bounded time for an entry pulse
	task automatic wait_entry;
		got = 1'b0;
		repeat (40) begin
			@(negedge clock);
			if (entry_start === 1'b1) begin
				got = 1'b1;
				break;
			end
		end
	endtask
	// Drop every request and let the sync stages drain
	task automatic quiet;
		@(posedge clock);
		{halt_pin, irq_pin, io_bus_err_pin, wr_err_req, rd_err_req} <= '0;
		{perf_mon_req, timer_req, net_req, sw_req} <= '0;
		repeat (15) @(posedge clock);
		cur_level <= 5'h00;
	endtask
	// Halt at the top current level still enters firmware
	task automatic t_halt;
		cur_level <= 5'h1f;
		halt_pin <= 1'b1;
		wait_entry();
		chk(got, 1'b1);
		chk(entry_to_firmware, 1'b1);
		chk(saved_halt_code, 6'h02);
		chk({new_level, saved_map_en, saved_pc, saved_psw}, {5'h1f, 1'b1, cur_pc, cur_psw});
		quiet();
	endtask
	// Eight sources alone (no halt or lines 2 to 0), fast and slow acceptance
	task automatic t_sources;
		logic [4:0] lv [8] = '{5'h1d, 5'h1a, 5'h1a, 5'h1b, 5'h17, 5'h16, 5'h15, 5'h01};
		logic [9:0] vc [8] = '{10'h060, 10'h054, 10'h054, 10'h000, 10'h000, 10'h0c0,
			10'h104, 10'h084};
		for (int k = 0; k < 8; k++) begin
			@(posedge clock);
			slow <= k[0];
			cur_pc <= 32'h0000_1000 + k;
			cur_psw <= 32'h0000_0004 + k;
			case (k)
				0: wr_err_req <= 1'b1;
				1: rd_err_req <= 1'b1;
				2: io_bus_err_pin <= 1'b1;
				3: perf_mon_req <= 1'b1;
				4: irq_pin[3] <= 1'b1;
				5: timer_req <= 1'b1;
				6: net_req <= 1'b1;
				default: sw_req[0] <= 1'b1;
			endcase
			wait_entry();
			chk(new_level, lv[k]);
			if (k != 3) chk(vector_offset, vc[k]);
			chk({entry_microcode, entry_to_firmware}, {k == 3, 1'b0});
			chk({saved_pc, saved_psw}, {cur_pc, cur_psw});
			quiet();
		end
	endtask
	// Blocking by current level, then line 2 beating the timer
	task automatic t_prio;
		cur_level <= 5'h16;
		timer_req <= 1'b1;
		sw_req <= 15'h7fff;
		irq_pin[2] <= 1'b1;
		wait_entry();
		chk(got, 1'b0);
		@(posedge clock);
		cur_level <= 5'h15;
		wait_entry();
		chk({new_level, vector_offset}, {5'h16, 10'h000});
		quiet();
	endtask
	// Every category, with trap, fault and restorable abort
	task automatic t_exc;
		exc_kind_t kd;
		logic      rs;
		for (int c = 0; c < 6; c++) begin
			kd = exc_kind_t'(c % 3);
			rs = c == 2; // Only the first abort is restorable
			@(posedge clock);
			exc_in <= '{1'b1, exc_cat_t'(c), kd, rs, 32'h2000 + c, 32'h3000 + c};
			@(posedge clock);
			exc_in.valid <= 1'b0;
			repeat (12) begin
				@(negedge clock);
				if (exc_valid === 1'b1) break;
			end
			chk(exc_valid, 1'b1);
			chk(exc_cat, c);
			chk({exc_kind, exc_restore}, {(kd == exc_abort && rs) ? exc_fault : kd, rs});
			chk(saved_pc, kd == exc_trap ? 32'h3000 + c : 32'h2000 + c);
		end
	endtask
	// Verdict and end of run
	task automatic results;
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		t_halt();
		t_sources();
		t_prio();
		t_exc();
		results();
	end
	// Watchdog well beyond the expected few hundred cycles
	initial begin
		#100000;
		errors++;
		results();
	end
endmodule
